// [hdl/typed_bank_pkg.sv]
package typed_bank_pkg;
  // register word indices, byte address is index times four
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_FLD_A = 4'h1;
  localparam logic [3:0] IDX_FLD_B = 4'h2;
  localparam logic [3:0] IDX_FLD_ERR = 4'h3;
  localparam logic [3:0] IDX_FLD_HIDE = 4'h4;
  localparam logic [3:0] IDX_CNT_LOCK_LO = 4'h5;
  localparam logic [3:0] IDX_CNT_LOCK_HI = 4'h6;
  localparam logic [3:0] IDX_CNT_TWIN_LO = 4'h7;
  localparam logic [3:0] IDX_CNT_TWIN_HI = 4'h8;
  localparam logic [3:0] IDX_STATUS = 4'h9;
  // control and status fields
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_HIDE_BIT = 1;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [63:0] CNT_RST = 64'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    AT_RO, AT_RW, AT_WONCE, AT_WONLY, AT_W1S, AT_W1C, AT_W0C,
    AT_ERR_RD, AT_ERR_WR, AT_ERR_W0, AT_ERR_W1, AT_HIDDEN, AT_RSVD1, AT_RSVD0
  } access_t;
  typedef enum logic [1:0] {RC_WARM, RC_COLD, RC_FIXED} rclass_t;
  typedef enum logic [1:0] {CD_NONE, CD_HIDE, CD_LOCK} cond_t;
  typedef struct packed {
    logic [3:0] reg_idx;
    logic [4:0] lsb;
    logic [5:0] width;
    access_t at;      // type while condition is false
    access_t alt;     // type while condition is true
    cond_t cond;
    logic readable;   // read combined with a write-style type
    rclass_t rc;
    logic [31:0] rst_val;
  } field_t;

  localparam int NUM_FIELDS = 13;
  localparam field_t FIELDS [NUM_FIELDS] = '{
    '{IDX_FLD_A, 5'd0, 6'd8, AT_RW, AT_RW, CD_NONE, 1'b1, RC_WARM, 32'h0000005a},
    '{IDX_FLD_A, 5'd8, 6'd8, AT_W1S, AT_W1S, CD_NONE, 1'b1, RC_WARM, 32'h00000000},
    '{IDX_FLD_A, 5'd16, 6'd8, AT_W1C, AT_W1C, CD_NONE, 1'b1, RC_WARM, 32'h00000000},
    '{IDX_FLD_A, 5'd24, 6'd8, AT_W0C, AT_W0C, CD_NONE, 1'b1, RC_WARM, 32'hff000000},
    '{IDX_FLD_B, 5'd0, 6'd8, AT_WONCE, AT_WONCE, CD_NONE, 1'b1, RC_WARM, 32'h00000000},
    '{IDX_FLD_B, 5'd8, 6'd8, AT_WONLY, AT_WONLY, CD_NONE, 1'b0, RC_WARM, 32'h00000000},
    '{IDX_FLD_B, 5'd16, 6'd8, AT_RW, AT_RW, CD_NONE, 1'b1, RC_COLD, 32'h00330000},
    '{IDX_FLD_B, 5'd24, 6'd8, AT_RO, AT_RO, CD_NONE, 1'b1, RC_FIXED, 32'ha5000000},
    '{IDX_FLD_ERR, 5'd0, 6'd8, AT_ERR_RD, AT_ERR_RD, CD_NONE, 1'b0, RC_WARM, 32'h00000011},
    '{IDX_FLD_ERR, 5'd8, 6'd8, AT_ERR_WR, AT_ERR_WR, CD_NONE, 1'b1, RC_WARM, 32'h00002200},
    '{IDX_FLD_ERR, 5'd16, 6'd8, AT_ERR_W0, AT_ERR_W0, CD_NONE, 1'b1, RC_WARM, 32'h00ff0000},
    '{IDX_FLD_ERR, 5'd24, 6'd8, AT_ERR_W1, AT_ERR_W1, CD_NONE, 1'b1, RC_WARM, 32'h00000000},
    '{IDX_FLD_HIDE, 5'd0, 6'd32, AT_RW, AT_HIDDEN, CD_HIDE, 1'b1, RC_WARM, 32'h12345678}
  };
  // field positions in the table
  localparam int F_W1S = 1;
  localparam int F_W1C = 2;
  localparam int F_W0C = 3;
  localparam int F_WONCE = 4;
  localparam int F_FIXED = 7;
  localparam int F_HIDE = 12;
endpackage : typed_bank_pkg

// [hdl/typed_field_register_bank.sv]
// Notes on behaviour
// - read-only fields read back, ignore writes
// - write-once takes first write after reset
// - writing one sets bit, zero untouched
// - writing one clears bit, zero untouched
// - writing zero clears bit, one ignored
// - write-only fields store, reads return zero
// - error on listed reads and writes
// - inaccessible fields neither read nor written
// - volatile fields change by hardware too
// - condition on another field selects type
// - cycle counter counts only while active
// - lock bit makes counter read-only
// - reset value present after reset release
// - cold fields survive warm reset
// - fixed fields hold their value always
// - read combines only with listed types
`timescale 1ns/1ps

module typed_field
  import typed_bank_pkg::*;
#(
  parameter field_t F = FIELDS[0]
) (
  input wire logic clk_i,             // bank clock
  input wire logic warm_rst_i,        // warm reset, async high
  input wire logic cold_rst_i,        // cold reset, async high
  input wire logic wr_i,              // write to this field's word
  input wire logic rd_i,              // read of this field's word
  input wire logic hide_i,            // hide control
  input wire logic lock_i,            // lock control
  input wire logic [31:0] wdata_i,    // write data
  input wire logic [31:0] wbits_i,    // bit enables from strobes
  input wire logic [31:0] hw_set_i,   // hardware set bits
  output logic [31:0] val_o,          // stored value in place
  output logic [31:0] rdata_o,        // value seen by reads
  output logic err_rd_o,              // read error
  output logic err_wr_o               // write error
);
  localparam logic [63:0] ONES = (64'h1 << F.width) - 64'h1;
  localparam logic [31:0] FMASK = ONES[31:0] << F.lsb;
  logic [31:0] val;
  logic [31:0] next_val;
  logic [31:0] m;
  logic once_done;
  logic cond;
  logic readable;
  logic rst_any;
  access_t at;
  assign cond = (F.cond == CD_HIDE) ? hide_i : (F.cond == CD_LOCK) ? lock_i : 1'b0;
  assign at = cond ? F.alt : F.at;
  assign m = wbits_i & FMASK & {32{wr_i}};
  assign rst_any = cold_rst_i | (warm_rst_i & (F.rc == RC_WARM));
  // next value per access type
  always_comb begin
    next_val = val;
    case (at)
      AT_RW, AT_WONLY: next_val = (val & ~m) | (wdata_i & m);
      AT_WONCE: if (!once_done) next_val = (val & ~m) | (wdata_i & m);
      AT_W1S: next_val = val | (wdata_i & m);
      AT_W1C: next_val = val & ~(wdata_i & m);
      AT_W0C: next_val = val & ~(~wdata_i & m);
      default: next_val = val; // read-only, error, hidden, reserved
    endcase
    next_val = next_val | (hw_set_i & FMASK);
  end
  // reset value, class picks the reset
  always_ff @(posedge clk_i or posedge rst_any) begin
    if (rst_any) begin
      val <= F.rst_val & FMASK;
    end else begin
      val <= next_val & FMASK;
    end
  end
  // write-once latch
  always_ff @(posedge clk_i or posedge rst_any) begin
    if (rst_any) begin
      once_done <= 1'b0;
    end else if (at == AT_WONCE && (|m)) begin
      once_done <= 1'b1;
    end
  end
  assign val_o = (F.rc == RC_FIXED) ? (F.rst_val & FMASK) : val;
  assign readable = (at == AT_RO) || (at == AT_RW) || (F.readable &&
    ((at == AT_WONCE) || (at == AT_W1S) || (at == AT_W1C) || (at == AT_W0C) ||
     (at == AT_ERR_WR) || (at == AT_ERR_W0) || (at == AT_ERR_W1)));
  assign rdata_o = readable ? val_o : 32'h0;
  assign err_rd_o = rd_i && (at == AT_ERR_RD);
  assign err_wr_o = wr_i && (((at == AT_ERR_WR) && (|m)) || ((at == AT_ERR_W0) && (|(~wdata_i & m))) ||
    ((at == AT_ERR_W1) && (|(wdata_i & m))));
endmodule : typed_field

module typed_field_register_bank
  import typed_bank_pkg::*;
(
  input wire logic CLK_I,             // bank clock, 25 MHz
  input wire logic RST_I,             // warm reset, async high
  input wire logic COLD_RST_I,        // cold reset, async high
  input wire logic CORE_ACTIVE_I,     // core in active power state, pin
  input wire logic [7:0] HW_EVENT_I,  // hardware events, pin
  input wire logic AWVALID,           // write address valid
  output logic AWREADY,               // write address ready
  input wire logic [7:0] AWADDR,      // write byte address
  input wire logic [2:0] AWPROT,      // unused
  input wire logic WVALID,            // write data valid
  output logic WREADY,                // write data ready
  input wire logic [31:0] WDATA,      // write data
  input wire logic [3:0] WSTRB,       // byte strobes
  output logic BVALID,                // write response valid
  input wire logic BREADY,            // write response ready
  output logic [1:0] BRESP,           // write response
  input wire logic ARVALID,           // read address valid
  output logic ARREADY,               // read address ready
  input wire logic [7:0] ARADDR,      // read byte address
  input wire logic [2:0] ARPROT,      // unused
  output logic RVALID,                // read data valid
  input wire logic RREADY,            // read data ready
  output logic [31:0] RDATA,          // read data
  output logic [1:0] RRESP            // read response
);
  logic aw_held;
  logic w_held;
  logic [3:0] w_idx;
  logic [31:0] wdata;
  logic [31:0] wbits;
  logic do_write;
  logic rd_take;
  logic [3:0] r_idx;
  logic [31:0] rd_word;
  logic rd_err;
  logic wr_err;
  logic [1:0] ctrl;
  logic [63:0] cnt_lock;
  logic [63:0] cnt_twin;
  logic [1:0] active_sync;
  logic [15:0] event_sync;
  logic [31:0] fval [NUM_FIELDS];
  logic [31:0] frd [NUM_FIELDS];
  logic [NUM_FIELDS-1:0] ferr_r;
  logic [NUM_FIELDS-1:0] ferr_w;

  // pin synchronisers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      active_sync <= 2'h0;
      event_sync <= 16'h0;
    end else begin
      active_sync <= {active_sync[0], CORE_ACTIVE_I};
      event_sync <= {event_sync[7:0], HW_EVENT_I};
    end
  end

  // write channel acceptance
  assign AWREADY = !aw_held && !BVALID;
  assign WREADY = !w_held && !BVALID;
  assign do_write = aw_held && w_held && !BVALID;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      w_idx <= 4'h0;
      wdata <= 32'h0;
      wbits <= 32'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        w_idx <= AWADDR[5:2];
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        wdata <= WDATA;
        wbits <= {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response
  assign wr_err = |ferr_w;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (do_write) begin
      BVALID <= 1'b1;
      BRESP <= (w_idx > IDX_STATUS) ? RESP_DECERR : (wr_err ? RESP_SLVERR : RESP_OKAY);
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  for (genvar i = 0; i < NUM_FIELDS; i++) begin : g_field
    typed_field #(.F(FIELDS[i])) u_field (
      .clk_i(CLK_I),
      .warm_rst_i(RST_I),
      .cold_rst_i(COLD_RST_I),
      .wr_i(do_write && (w_idx == FIELDS[i].reg_idx)),
      .rd_i(rd_take && (r_idx == FIELDS[i].reg_idx)),
      .hide_i(ctrl[CTRL_HIDE_BIT]),
      .lock_i(ctrl[CTRL_LOCK_BIT]),
      .wdata_i(wdata),
      .wbits_i(wbits),
      .hw_set_i((i == F_W1C) ? {8'h0, event_sync[15:8], 16'h0} : 32'h0),
      .val_o(fval[i]),
      .rdata_o(frd[i]),
      .err_rd_o(ferr_r[i]),
      .err_wr_o(ferr_w[i])
    );
  end

  // control word, warm reset
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl <= CTRL_RST;
    end else if (do_write && w_idx == IDX_CTRL) begin
      ctrl <= (ctrl & ~wbits[1:0]) | (wdata[1:0] & wbits[1:0]);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_lock <= CNT_RST;
    end else if (do_write && !ctrl[CTRL_LOCK_BIT] && w_idx == IDX_CNT_LOCK_LO) begin
      cnt_lock[31:0] <= (cnt_lock[31:0] & ~wbits) | (wdata & wbits);
    end else if (do_write && !ctrl[CTRL_LOCK_BIT] && w_idx == IDX_CNT_LOCK_HI) begin
      cnt_lock[63:32] <= (cnt_lock[63:32] & ~wbits) | (wdata & wbits);
    end else if (active_sync[1]) begin
      cnt_lock <= cnt_lock + 64'h1;
    end
  end

  // writable twin counter, separate storage
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_twin <= CNT_RST;
    end else if (do_write && w_idx == IDX_CNT_TWIN_LO) begin
      cnt_twin[31:0] <= (cnt_twin[31:0] & ~wbits) | (wdata & wbits);
    end else if (do_write && w_idx == IDX_CNT_TWIN_HI) begin
      cnt_twin[63:32] <= (cnt_twin[63:32] & ~wbits) | (wdata & wbits);
    end else if (active_sync[1]) begin
      cnt_twin <= cnt_twin + 64'h1;
    end
  end

  // read word decode
  assign rd_take = ARVALID && ARREADY;
  assign r_idx = ARADDR[5:2];
  always_comb begin
    rd_word = 32'h0;
    rd_err = |ferr_r;
    if (r_idx == IDX_CTRL) begin
      rd_word = {30'h0, ctrl};
    end else if (r_idx == IDX_CNT_LOCK_LO) begin
      rd_word = cnt_lock[31:0];
    end else if (r_idx == IDX_CNT_LOCK_HI) begin
      rd_word = cnt_lock[63:32];
    end else if (r_idx == IDX_CNT_TWIN_LO) begin
      rd_word = cnt_twin[31:0];
    end else if (r_idx == IDX_CNT_TWIN_HI) begin
      rd_word = cnt_twin[63:32];
    end else if (r_idx == IDX_STATUS) begin
      rd_word = {31'h0, active_sync[1]};
    end else begin
      for (int i = 0; i < NUM_FIELDS; i++) begin
        if (FIELDS[i].reg_idx == r_idx) begin
          rd_word = rd_word | frd[i];
        end
      end
    end
  end

  // read response
  assign ARREADY = !RVALID;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= RESP_OKAY;
    end else if (rd_take) begin
      RVALID <= 1'b1;
      RDATA <= (r_idx > IDX_STATUS || rd_err) ? 32'h0 : rd_word;
      RRESP <= (r_idx > IDX_STATUS) ? RESP_DECERR : (rd_err ? RESP_SLVERR : RESP_OKAY);
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I || COLD_RST_I);
  property p_fixed_hold;
    g_field[F_FIXED].u_field.val == FIELDS[F_FIXED].rst_val;
  endproperty
  a_fixed_hold: assert property (p_fixed_hold) else $error("fixed field changed");
  property p_once_locks;
    $past(g_field[F_WONCE].u_field.once_done) |-> $stable(fval[F_WONCE]);
  endproperty
  a_once_locks: assert property (p_once_locks) else $error("write-once field rewritten");
  property p_set_one;
    do_write && w_idx == IDX_FLD_A |=> ((fval[F_W1S] & $past(wdata & wbits)) & 32'h0000ff00) ==
      ($past(wdata & wbits) & 32'h0000ff00);
  endproperty
  a_set_one: assert property (p_set_one) else $error("set-on-one bit not set");
  property p_clear_one;
    do_write && w_idx == IDX_FLD_A && event_sync[15:8] == 8'h0 |=>
      (fval[F_W1C] & $past(wdata & wbits) & 32'h00ff0000) == 32'h0;
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("clear-on-one bit not cleared");
  property p_clear_zero;
    do_write && w_idx == IDX_FLD_A |=> (fval[F_W0C] & ~$past(wdata) & $past(wbits) & 32'hff000000) == 32'h0 &&
      (fval[F_W0C] & ~$past(fval[F_W0C])) == 32'h0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear-on-zero misbehaved");
  property p_err_read;
    rd_take && r_idx == IDX_FLD_ERR |=> RVALID && RRESP == RESP_SLVERR && RDATA == 32'h0;
  endproperty
  a_err_read: assert property (p_err_read) else $error("error-on-read not flagged");
  property p_hidden_read;
    rd_take && r_idx == IDX_FLD_HIDE && ctrl[CTRL_HIDE_BIT] |=> RDATA == 32'h0 ##0 RVALID;
  endproperty
  a_hidden_read: assert property (p_hidden_read) else $error("hidden field readable");
  property p_hidden_write;
    ctrl[CTRL_HIDE_BIT] && do_write && w_idx == IDX_FLD_HIDE |=> $stable(fval[F_HIDE]);
  endproperty
  a_hidden_write: assert property (p_hidden_write) else $error("hidden field written");
  property p_count_active;
    active_sync[1] && !(do_write && (w_idx == IDX_CNT_LOCK_LO || w_idx == IDX_CNT_LOCK_HI)) |=>
      cnt_lock == $past(cnt_lock) + 64'h1;
  endproperty
  a_count_active: assert property (p_count_active) else $error("counter missed a cycle");
  property p_count_idle;
    !active_sync[1] && !do_write |=> $stable(cnt_lock);
  endproperty
  a_count_idle: assert property (p_count_idle) else $error("counter moved while idle");
  property p_lock_ro;
    ctrl[CTRL_LOCK_BIT] && !active_sync[1] |=> $stable(cnt_lock);
  endproperty
  a_lock_ro: assert property (p_lock_ro) else $error("locked counter changed");
  c_err_write: cover property (do_write && wr_err ##1 BVALID && BRESP == RESP_SLVERR);
  c_once_twice: cover property (g_field[F_WONCE].u_field.once_done && do_write && w_idx == IDX_FLD_B);
  c_lock_write: cover property (ctrl[CTRL_LOCK_BIT] && do_write && w_idx == IDX_CNT_LOCK_LO);
  c_decerr: cover property (RVALID && RRESP == RESP_DECERR);
endmodule : typed_field_register_bank

// [verification/tb.sv]
`timescale 1ns/1ps

`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end

module tb
  import typed_bank_pkg::*;
;
  logic CLK_I, RST_I, COLD_RST_I, CORE_ACTIVE_I;
  logic [7:0] HW_EVENT_I, AWADDR, ARADDR;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  int mismatches, cmp_count;
  int seed;
  logic [31:0] cur_a, d, s, ca, cb;
  logic [1:0] r;

  typed_field_register_bank u_dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .COLD_RST_I(COLD_RST_I), .CORE_ACTIVE_I(CORE_ACTIVE_I),
    .HW_EVENT_I(HW_EVENT_I), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP)
  );

  // 25 mhz bank clock
  always #20 CLK_I = ~CLK_I;

  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // expected word of the mixed-type field word
  function automatic logic [31:0] exp_a(logic [31:0] o, logic [31:0] w, logic [3:0] st);
    logic [31:0] m, n;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    n = {o[31:24] & w[31:24], o[23:16] & ~w[23:16], o[15:8] | w[15:8], w[7:0]};
    return (n & m) | (o & ~m);
  endfunction : exp_a

  // write transaction, bounded wait for the response
  task automatic wr(input logic [3:0] i, input logic [31:0] wd, input logic [3:0] st, output logic [1:0] rs);
    int n;
    @(posedge CLK_I);
    AWVALID <= 1'b1;
    AWADDR <= {2'b00, i, 2'b00};
    WVALID <= 1'b1;
    WDATA <= wd;
    WSTRB <= st;
    BREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK_I);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) break;
    end
    rs = BRESP;
    BREADY <= 1'b0;
    if (n == 50) begin
      mismatches++;
      results();
    end
  endtask : wr

  // read transaction, bounded wait for the data
  task automatic rd(input logic [3:0] i, output logic [31:0] rdv, output logic [1:0] rs);
    int n;
    @(posedge CLK_I);
    ARVALID <= 1'b1;
    ARADDR <= {2'b00, i, 2'b00};
    RREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK_I);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) break;
    end
    rdv = RDATA;
    rs = RRESP;
    RREADY <= 1'b0;
    if (n == 50) begin
      mismatches++;
      results();
    end
  endtask : rd

  // write and compare the response
  task automatic wc(input logic [3:0] i, input logic [31:0] wd, input logic [3:0] st, input logic [1:0] er);
    logic [1:0] rs;
    wr(i, wd, st, rs);
    `CHK("bresp", er, rs)
  endtask : wc

  // read and compare data and response
  task automatic rc(input logic [3:0] i, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] rs;
    rd(i, v, rs);
    `CHK("rdata", ed, v)
    `CHK("rresp", er, rs)
  endtask : rc

  // warm reset, optionally with cold reset
  task automatic rst(input logic cold);
    @(posedge CLK_I);
    RST_I <= 1'b1;
    COLD_RST_I <= cold;
    repeat (3) @(posedge CLK_I);
    RST_I <= 1'b0;
    COLD_RST_I <= 1'b0;
  endtask : rst

  initial begin
    CLK_I = 1'b0;
    RST_I = 1'b1;
    COLD_RST_I = 1'b1;
    CORE_ACTIVE_I = 1'b0;
    HW_EVENT_I = 8'h00;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    WDATA = 32'h0;
    WSTRB = 4'h0;
    seed = 32'h384fbc02;
    mismatches = 0;
    cmp_count = 0;
    repeat (8) @(posedge CLK_I);
    RST_I <= 1'b0;
    COLD_RST_I <= 1'b0;
    rc(IDX_CTRL, 32'h0, RESP_OKAY);
    rc(IDX_FLD_A, 32'hff00005a, RESP_OKAY);
    rc(IDX_FLD_B, 32'ha5330000, RESP_OKAY);
    rc(IDX_FLD_HIDE, 32'h12345678, RESP_OKAY);
    rc(IDX_STATUS, 32'h0, RESP_OKAY);
    rc(4'ha, 32'h0, RESP_DECERR);
    wc(4'hb, 32'hffffffff, 4'hf, RESP_DECERR);
    cur_a = 32'hff00005a;
    for (int k = 0; k < 24; k++) begin
      d = $random(seed);
      s = $random(seed);
      if (k == 0) s = 32'hf;
      wc(IDX_FLD_A, d, s[3:0], RESP_OKAY);
      cur_a = exp_a(cur_a, d, s[3:0]);
      rc(IDX_FLD_A, cur_a, RESP_OKAY);
    end
    HW_EVENT_I <= 8'h81;
    repeat (4) @(posedge CLK_I);
    HW_EVENT_I <= 8'h00;
    repeat (4) @(posedge CLK_I);
    cur_a[23:16] = cur_a[23:16] | 8'h81;
    rc(IDX_FLD_A, cur_a, RESP_OKAY);
    wc(IDX_FLD_A, 32'h00ff0000, 4'h4, RESP_OKAY);
    cur_a[23:16] = 8'h00;
    rc(IDX_FLD_A, cur_a, RESP_OKAY);
    wc(IDX_FLD_B, 32'hffffffc3, 4'hf, RESP_OKAY);
    wc(IDX_FLD_B, 32'h0000003c, 4'h1, RESP_OKAY);
    rc(IDX_FLD_B, 32'ha5ff00c3, RESP_OKAY);
    wc(IDX_FLD_B, 32'h00770000, 4'h4, RESP_OKAY);
    rc(IDX_FLD_ERR, 32'h0, RESP_SLVERR);
    wc(IDX_FLD_ERR, 32'h00005500, 4'h2, RESP_SLVERR);
    wc(IDX_FLD_ERR, 32'h00ff0000, 4'h4, RESP_OKAY);
    wc(IDX_FLD_ERR, 32'h00fe0000, 4'h4, RESP_SLVERR);
    wc(IDX_FLD_ERR, 32'h00000000, 4'h8, RESP_OKAY);
    wc(IDX_FLD_ERR, 32'h01000000, 4'h8, RESP_SLVERR);
    wc(IDX_FLD_HIDE, 32'hcafe0001, 4'hf, RESP_OKAY);
    wc(IDX_CTRL, 32'h2, 4'h1, RESP_OKAY);
    rc(IDX_FLD_HIDE, 32'h0, RESP_OKAY);
    wc(IDX_FLD_HIDE, 32'h0, 4'hf, RESP_OKAY);
    wc(IDX_CTRL, 32'h0, 4'h1, RESP_OKAY);
    rc(IDX_FLD_HIDE, 32'hcafe0001, RESP_OKAY);
    rc(IDX_CNT_LOCK_LO, 32'h0, RESP_OKAY);
    wc(IDX_CTRL, 32'h1, 4'h1, RESP_OKAY);
    wc(IDX_CNT_LOCK_LO, 32'h00001234, 4'hf, RESP_OKAY);
    rc(IDX_CNT_LOCK_LO, 32'h0, RESP_OKAY);
    wc(IDX_CTRL, 32'h0, 4'h1, RESP_OKAY);
    wc(IDX_CNT_LOCK_LO, 32'h00001234, 4'hf, RESP_OKAY);
    wc(IDX_CNT_TWIN_LO, 32'h0000ffff, 4'hf, RESP_OKAY);
    rc(IDX_CNT_LOCK_LO, 32'h00001234, RESP_OKAY);
    rc(IDX_CNT_TWIN_LO, 32'h0000ffff, RESP_OKAY);
    CORE_ACTIVE_I <= 1'b1;
    repeat (6) @(posedge CLK_I);
    rc(IDX_STATUS, 32'h1, RESP_OKAY);
    wc(IDX_CTRL, 32'h1, 4'h1, RESP_OKAY);
    rd(IDX_CNT_LOCK_LO, ca, r);
    rd(IDX_CNT_LOCK_LO, cb, r);
    `CHK("count step", 1'b1, (cb - ca >= 32'h1 && cb - ca < 32'h20))
    CORE_ACTIVE_I <= 1'b0;
    repeat (6) @(posedge CLK_I);
    rd(IDX_CNT_LOCK_LO, ca, r);
    rd(IDX_CNT_LOCK_LO, cb, r);
    `CHK("count idle", ca, cb)
    rst(1'b0);
    rc(IDX_FLD_B, 32'ha5770000, RESP_OKAY);
    rc(IDX_FLD_A, 32'hff00005a, RESP_OKAY);
    rc(IDX_CNT_LOCK_HI, 32'h0, RESP_OKAY);
    wc(IDX_FLD_B, 32'h00000011, 4'h1, RESP_OKAY);
    rc(IDX_FLD_B, 32'ha5770011, RESP_OKAY);
    rst(1'b1);
    rc(IDX_FLD_B, 32'ha5330000, RESP_OKAY);
    results();
  end
endmodule : tb
